// >>> src/afepc_ctrl.sv
// How it works
// - Power bit 0 set stops the red converter; clear keeps it running.
// - Power bit 1 set stops the green converter; clear keeps it running.
// - Power bit 2 set stops the blue converter; clear keeps it running.
// - Power bit 3 stops the pixel clock loop; upper four bits stay zero.
// - Clamp bits 6:4 pick one shared on-resistance; code zero disconnects.
// - Clamp codes 1 to 7 give 1600 down to 228 ohms.
// - Sampling phase chooses one of 64 positions per pixel.
// - Pixel clock loop needs only the pixels-per-line setting from firmware.
// - Enabled black-level loop measures each channel and trims its 10-bit offset.
// - Each correction is one quarter-LSB step, at most once per window.
// - Once locked the offset code stays put while black holds steady.
// - Manual 8-bit offset shifts output by at most 64 codes each way.
// - Loop off hands the 10-bit offset codes to firmware writes.
// - Gain registers never touch offset correction.
// - Two-bit field averages 16, 32, 64 or 128 black pixels per line.
// - Three-bit field sets the window to 2^(5+n) lines.
//
// Our own choice: the APB register port.
module afepc_ctrl
  import afepc_pkg::*;
(
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [afepc_pkg::APB_AW-1:0] paddr,
  input  wire logic [afepc_pkg::APB_DW-1:0] pwdata,
  output logic      [afepc_pkg::APB_DW-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Black-level samples
  input  wire logic [7:0]                 adc_red,
  input  wire logic [7:0]                 adc_green,
  input  wire logic [7:0]                 adc_blue,
  input  wire logic                       black_sample_valid,
  input  wire logic                       line_end,
  // Power-down controls
  output logic                            pd_red,
  output logic                            pd_green,
  output logic                            pd_blue,
  output logic                            pd_pll,
  // Clamp
  output logic                            clamp_connect,
  output logic      [10:0]                clamp_ohms,
  // Tuning and crystal
  output logic      [7:0]                 video_tuning_code,
  output logic      [7:0]                 crystal_comp_value,
  // Pixel clock loop
  output logic      [5:0]                 sample_phase,
  output logic      [11:0]                pixels_per_line,
  // Gain per channel
  output logic      [7:0]                 gain_red,
  output logic      [7:0]                 gain_green,
  output logic      [7:0]                 gain_blue,
  // Manual offset shift per channel
  output logic      [7:0]                 ofs_shift_red,
  output logic      [7:0]                 ofs_shift_green,
  output logic      [7:0]                 ofs_shift_blue,
  // Offset converter codes
  output logic      [9:0]                 offset_dac_red,
  output logic      [9:0]                 offset_dac_green,
  output logic      [9:0]                 offset_dac_blue
);

  import afepc_pkg::*;

  // ==========================================================
  // Storage
  logic [3:0]  pwr_ff;
  logic [7:0]  tune_ff;
  logic [6:0]  clamp_ff;
  logic [7:0]  xtal_ff;
  logic [6:0]  blc_ff;
  logic [5:0]  phase_ff;
  logic [11:0] pixcnt_ff;
  logic [7:0]  gain_ff     [NUM_CH];
  logic [7:0]  ofs_ff      [NUM_CH];
  logic [7:0]  shift_ff    [NUM_CH];
  logic [9:0]  dac_code    [NUM_CH];
  logic        ch_locked   [NUM_CH];
  logic [7:0]  ch_sample   [NUM_CH];
  logic        clamp_con_ff;
  logic [10:0] clamp_ohm_ff;

  // ==========================================================
  // APB handshake
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [7:0]  idx;
  logic        aligned;
  logic        setup;
  logic        access;
  logic        wr_ok;
  logic        rd_hit;
  logic [31:0] rd_word;
  logic        loop_on;

  assign idx     = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign setup   = psel && !penable;
  assign access  = psel && penable && pready_ff;
  // Writes land only at the access edge, never in setup
  assign wr_ok   = access && pwrite && aligned && rd_hit;
  assign loop_on = blc_ff[BLC_EN_BIT];

  assign ch_sample[0] = adc_red;
  assign ch_sample[1] = adc_green;
  assign ch_sample[2] = adc_blue;

  // Read decode; also serves as the map of legal indices
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (idx)
      IDX_PWR:    rd_word = {28'h000_0000, pwr_ff};
      IDX_TUNE:   rd_word = {24'h00_0000, tune_ff};
      IDX_CLAMP:  rd_word = {25'h000_0000, clamp_ff};
      IDX_XTAL:   rd_word = {24'h00_0000, xtal_ff};
      IDX_BLC:    rd_word = {25'h000_0000, blc_ff};
      IDX_PHASE:  rd_word = {26'h000_0000, phase_ff};
      IDX_PIXCNT: rd_word = {20'h0_0000, pixcnt_ff};
      IDX_STATUS: rd_word = {28'h000_0000, loop_on, ch_locked[2], ch_locked[1], ch_locked[0]};
      default:    rd_hit  = 1'b0;
    endcase
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (idx == 8'(IDX_GAIN_R + 8'(ch))) begin
        rd_hit  = 1'b1;
        rd_word = {24'h00_0000, gain_ff[ch]};
      end
      if (idx == 8'(IDX_OFS_R + 8'(ch))) begin
        rd_hit  = 1'b1;
        rd_word = {24'h00_0000, ofs_ff[ch]};
      end
      if (idx == 8'(IDX_DAC_R + 8'(ch))) begin
        rd_hit  = 1'b1;
        rd_word = {22'h00_0000, dac_code[ch]};
      end
    end
  end

  // Answer one cycle after setup: access phase never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup && !(aligned && rd_hit);
      if (setup && !pwrite && aligned && rd_hit) begin
        prdata_ff <= rd_word;
      end else if (setup) begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Power control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_ff <= RST_PWR;
    end else if (wr_ok && (idx == IDX_PWR)) begin
      // Upper nibble is not stored and reads back zero
      pwr_ff <= pwdata[PWR_PLL_BIT:0];
    end
  end

  // ==========================================================
  // Tuning and crystal compensation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tune_ff <= RST_TUNE;
      xtal_ff <= RST_XTAL;
    end else if (wr_ok && (idx == IDX_TUNE)) begin
      tune_ff <= pwdata[7:0];
    end else if (wr_ok && (idx == IDX_XTAL)) begin
      xtal_ff <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Restore clamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clamp_ff <= RST_CLAMP;
    end else if (wr_ok && (idx == IDX_CLAMP)) begin
      clamp_ff <= pwdata[6:0];
    end
  end

  // One shared resistance for all three channels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clamp_con_ff <= 1'b0;
      clamp_ohm_ff <= 11'h000;
    end else begin
      clamp_con_ff <= (clamp_ff[CLAMP_MSB:CLAMP_LSB] != 3'h0);
      clamp_ohm_ff <= CLAMP_OHMS[clamp_ff[CLAMP_MSB:CLAMP_LSB]];
    end
  end

  // ==========================================================
  // Pixel clock loop settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff  <= RST_PHASE;
      pixcnt_ff <= RST_PIXCNT;
    end else if (wr_ok && (idx == IDX_PHASE)) begin
      phase_ff  <= pwdata[5:0];
    end else if (wr_ok && (idx == IDX_PIXCNT)) begin
      // Only setting the loop needs across its whole lock range
      pixcnt_ff <= pwdata[11:0];
    end
  end

  // ==========================================================
  // Black-level loop configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blc_ff <= RST_BLC;
    end else if (wr_ok && (idx == IDX_BLC)) begin
      blc_ff <= pwdata[6:0];
    end
  end

  // ==========================================================
  // Per-channel gain, manual offset and servo
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic dac_wr;

    assign dac_wr = wr_ok && (idx == 8'(IDX_DAC_R + 8'(ch)));

    // Gain stands apart; nothing in the offset path reads it
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        gain_ff[ch] <= RST_GAIN;
      end else if (wr_ok && (idx == 8'(IDX_GAIN_R + 8'(ch)))) begin
        gain_ff[ch] <= pwdata[7:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ofs_ff[ch] <= RST_OFS;
      end else if (wr_ok && (idx == 8'(IDX_OFS_R + 8'(ch)))) begin
        ofs_ff[ch] <= pwdata[7:0];
      end
    end

    // Raw value kept for read-back; the applied shift is limited
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        shift_ff[ch] <= RST_OFS;
      end else if (ofs_ff[ch] < OFS_MIN) begin
        shift_ff[ch] <= OFS_MIN;
      end else if (ofs_ff[ch] > OFS_MAX) begin
        shift_ff[ch] <= OFS_MAX;
      end else begin
        shift_ff[ch] <= ofs_ff[ch];
      end
    end

    afepc_servo u_servo (
      .pclk         (pclk),
      .presetn      (presetn),
      .loop_on      (loop_on),
      .hold         (pwr_ff[ch]),
      .width_sel    (blc_ff[BLC_W_MSB:BLC_W_LSB]),
      .tc_sel       (blc_ff[BLC_TC_MSB:BLC_TC_LSB]),
      .sample_valid (black_sample_valid),
      .sample       (ch_sample[ch]),
      .line_end     (line_end),
      .sw_wr        (dac_wr),
      .sw_code      (pwdata[9:0]),
      .dac_code     (dac_code[ch]),
      .locked       (ch_locked[ch])
    );
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign prdata             = prdata_ff;
  assign pready             = pready_ff;
  assign pslverr            = pslverr_ff;
  assign pd_red             = pwr_ff[0];
  assign pd_green           = pwr_ff[1];
  assign pd_blue            = pwr_ff[2];
  assign pd_pll             = pwr_ff[PWR_PLL_BIT];
  assign clamp_connect      = clamp_con_ff;
  assign clamp_ohms         = clamp_ohm_ff;
  assign video_tuning_code  = tune_ff;
  assign crystal_comp_value = xtal_ff;
  assign sample_phase       = phase_ff;
  assign pixels_per_line    = pixcnt_ff;
  assign gain_red           = gain_ff[0];
  assign gain_green         = gain_ff[1];
  assign gain_blue          = gain_ff[2];
  assign ofs_shift_red      = shift_ff[0];
  assign ofs_shift_green    = shift_ff[1];
  assign ofs_shift_blue     = shift_ff[2];
  assign offset_dac_red     = dac_code[0];
  assign offset_dac_green   = dac_code[1];
  assign offset_dac_blue    = dac_code[2];

endmodule

// >>> shared/afepc_pkg.sv
package afepc_pkg;

  // ==========================================================
  // Bus geometry
  localparam int unsigned APB_AW     = 12;
  localparam int unsigned APB_DW     = 32;
  localparam int unsigned NUM_CH     = 3;

  // ==========================================================
  // Register indices (byte address = index * 4)
  localparam logic [7:0] IDX_GAIN_R  = 8'h06;
  localparam logic [7:0] IDX_OFS_R   = 8'h09;
  localparam logic [7:0] IDX_BLC     = 8'h0C;
  localparam logic [7:0] IDX_PWR     = 8'h1B;
  localparam logic [7:0] IDX_TUNE    = 8'h1C;
  localparam logic [7:0] IDX_CLAMP   = 8'h23;
  localparam logic [7:0] IDX_XTAL    = 8'h2B;
  localparam logic [7:0] IDX_DAC_R   = 8'h30;
  localparam logic [7:0] IDX_PHASE   = 8'h33;
  localparam logic [7:0] IDX_PIXCNT  = 8'h34;
  localparam logic [7:0] IDX_STATUS  = 8'h35;

  // ==========================================================
  // Reset values
  localparam logic [3:0]  RST_PWR    = 4'h0;
  localparam logic [7:0]  RST_TUNE   = 8'h47;
  localparam logic [6:0]  RST_CLAMP  = 7'h08;
  localparam logic [7:0]  RST_XTAL   = 8'h14;
  localparam logic [7:0]  RST_GAIN   = 8'h55;
  localparam logic [7:0]  RST_OFS    = 8'h80;
  localparam logic [6:0]  RST_BLC    = 7'h41;
  localparam logic [9:0]  RST_DAC    = 10'h200;
  localparam logic [5:0]  RST_PHASE  = 6'h00;
  localparam logic [11:0] RST_PIXCNT = 12'h400;

  // ==========================================================
  // Field positions
  localparam int unsigned PWR_PLL_BIT  = 3;
  localparam int unsigned CLAMP_LSB    = 4;
  localparam int unsigned CLAMP_MSB    = 6;
  localparam int unsigned BLC_EN_BIT   = 0;
  localparam int unsigned BLC_W_LSB    = 2;
  localparam int unsigned BLC_W_MSB    = 3;
  localparam int unsigned BLC_TC_LSB   = 4;
  localparam int unsigned BLC_TC_MSB   = 6;
  localparam int unsigned ST_EN_BIT    = 3;

  // ==========================================================
  // Black-level loop constants
  localparam int unsigned AVG_BASE_LOG2 = 4;
  localparam int unsigned TC_BASE_LOG2  = 5;
  localparam logic [7:0]  AVG_MIN_PIX   = 8'h10;
  localparam logic [12:0] WIN_ONE       = 13'h0001;
  localparam logic [7:0]  BLACK_TARGET  = 8'h00;
  localparam logic [9:0]  DAC_MIN       = 10'h000;
  localparam logic [9:0]  DAC_MAX       = 10'h3FF;
  localparam logic [7:0]  OFS_MIN       = 8'h40;
  localparam logic [7:0]  OFS_MAX       = 8'hC0;

  // Clamp on-resistance in ohms per code, zero means disconnected
  localparam logic [10:0] CLAMP_OHMS [8] = '{11'h000, 11'h640, 11'h320, 11'h215,
                                            11'h190, 11'h140, 11'h10B, 11'h0E4};

endpackage

// >>> src/afepc_servo.sv
module afepc_servo
  import afepc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Control
  input  wire logic        loop_on,
  input  wire logic        hold,
  input  wire logic [1:0]  width_sel,
  input  wire logic [2:0]  tc_sel,
  // Black samples
  input  wire logic        sample_valid,
  input  wire logic [7:0]  sample,
  input  wire logic        line_end,
  // Firmware access
  input  wire logic        sw_wr,
  input  wire logic [9:0]  sw_code,
  // Results
  output logic      [9:0]  dac_code,
  output logic             locked
);

  // ==========================================================
  // Averaging and voting
  logic        [7:0]  pix_cnt_ff;
  logic        [14:0] sum_ff;
  logic signed [13:0] vote_ff;
  logic        [12:0] line_cnt_ff;
  logic        [9:0]  dac_ff;
  logic               locked_ff;
  logic        [7:0]  npix;
  logic        [7:0]  avg;
  logic        [12:0] win;
  logic               full_line;
  logic signed [13:0] nxt_vote;
  logic               win_end;

  assign npix      = 8'(AVG_MIN_PIX << width_sel);
  assign avg       = 8'(sum_ff >> (AVG_BASE_LOG2 + width_sel));
  assign win       = 13'(WIN_ONE << (TC_BASE_LOG2 + tc_sel));
  assign full_line = (pix_cnt_ff == npix);
  assign win_end   = line_end && (line_cnt_ff == 13'(win - WIN_ONE));

  always_comb begin
    nxt_vote = vote_ff;
    if (full_line && (avg > BLACK_TARGET)) begin
      nxt_vote = vote_ff + 14'sd1;
    end else if (full_line && (avg < BLACK_TARGET)) begin
      nxt_vote = vote_ff - 14'sd1;
    end
  end

  // Per-line accumulation; frozen while powered down, cleared while firmware-driven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_cnt_ff <= 8'h00;
      sum_ff     <= 15'h0000;
    end else if (!loop_on || line_end) begin
      pix_cnt_ff <= 8'h00;
      sum_ff     <= 15'h0000;
    end else if (!hold && sample_valid && !full_line) begin
      pix_cnt_ff <= pix_cnt_ff + 8'h01;
      sum_ff     <= sum_ff + 15'(sample);
    end
  end

  // Time-constant window over lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_cnt_ff <= 13'h0000;
      vote_ff     <= 14'sd0;
    end else if (!loop_on || hold) begin
      line_cnt_ff <= 13'h0000;
      vote_ff     <= 14'sd0;
    end else if (win_end) begin
      line_cnt_ff <= 13'h0000;
      vote_ff     <= 14'sd0;
    end else if (line_end) begin
      line_cnt_ff <= line_cnt_ff + 13'h0001;
      vote_ff     <= nxt_vote;
    end
  end

  // Offset code: one quarter-LSB step per window at most
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_ff    <= RST_DAC;
      locked_ff <= 1'b0;
    end else if (!loop_on) begin
      locked_ff <= 1'b0;
      if (sw_wr) begin
        dac_ff <= sw_code;
      end
    end else if (!hold && win_end) begin
      if ((nxt_vote > 14'sd0) && (dac_ff != DAC_MIN)) begin
        dac_ff    <= dac_ff - 10'h001;
        locked_ff <= 1'b0;
      end else if ((nxt_vote < 14'sd0) && (dac_ff != DAC_MAX)) begin
        dac_ff    <= dac_ff + 10'h001;
        locked_ff <= 1'b0;
      end else begin
        locked_ff <= 1'b1;
      end
    end
  end

  assign dac_code = dac_ff;
  assign locked   = locked_ff;

endmodule

// >>> tb/afepc_ctrl_monitor.sv
module afepc_ctrl_monitor (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // Watched controls
  input wire logic        line_end,
  input wire logic        pd_red,
  input wire logic        pd_green,
  input wire logic        pd_blue,
  input wire logic        pd_pll,
  input wire logic        clamp_connect,
  input wire logic [10:0] clamp_ohms,
  input wire logic [7:0]  ofs_shift_red,
  input wire logic [9:0]  offset_dac_red
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Helpers
  localparam logic [10:0] OHM [8] = '{11'h000, 11'h640, 11'h320, 11'h215,
                                      11'h190, 11'h140, 11'h10B, 11'h0E4};
  logic wr_dac_r;
  assign wr_dac_r = psel && penable && pready && pwrite && paddr == 12'h0C0;

  sequence s_wr(logic [11:0] a);
    psel && !penable && pwrite && paddr == a ##1 penable && pready;
  endsequence

  // ==========================================================
  // Properties
  property p_pd_red;
    s_wr(12'h06C) |=> pd_red == $past(pwdata[0]);
  endproperty
  property p_pd_green;
    s_wr(12'h06C) |=> pd_green == $past(pwdata[1]);
  endproperty
  property p_pd_blue;
    s_wr(12'h06C) |=> pd_blue == $past(pwdata[2]);
  endproperty
  property p_pd_pll;
    s_wr(12'h06C) |=> pd_pll == $past(pwdata[3]);
  endproperty
  property p_clamp_on;
    s_wr(12'h08C) |-> ##2 clamp_connect == ($past(pwdata[6:4], 2) != 3'h0);
  endproperty
  property p_clamp_ohms;
    s_wr(12'h08C) |-> ##2 clamp_ohms == OHM[$past(pwdata[6:4], 2)];
  endproperty
  // Servo moves one quarter step, only right after a line end
  property p_step;
    $changed(offset_dac_red) && !$past(wr_dac_r) |-> $past(line_end) &&
      (offset_dac_red == $past(offset_dac_red) + 10'h001 ||
       offset_dac_red == $past(offset_dac_red) - 10'h001);
  endproperty
  property p_hold;
    pd_red && $past(pd_red) && !$past(wr_dac_r) |-> $stable(offset_dac_red);
  endproperty
  property p_ofs_range;
    ofs_shift_red >= 8'h40 && ofs_shift_red <= 8'hC0;
  endproperty

  a_pd_red: assert property (p_pd_red)
    else $error("red power-down bit wrong");
  a_pd_green: assert property (p_pd_green)
    else $error("green power-down bit wrong");
  a_pd_blue: assert property (p_pd_blue)
    else $error("blue power-down bit wrong");
  a_pd_pll: assert property (p_pd_pll)
    else $error("clock loop power-down bit wrong");
  a_clamp_on: assert property (p_clamp_on)
    else $error("clamp connect wrong");
  a_clamp_ohms: assert property (p_clamp_ohms)
    else $error("clamp resistance wrong");
  a_step: assert property (p_step)
    else $error("offset step wrong");
  a_hold: assert property (p_hold)
    else $error("offset moved while powered down");
  a_ofs_range: assert property (p_ofs_range)
    else $error("manual offset out of range");
endmodule

// >>> tb/tb_top.sv
module tb_top
  import afepc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Signals
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, err, valid = 1'b0, line_end = 1'b0;
  logic [7:0]  adc = '0, tune, xtal, gain_red, gain_green, gain_blue, ofs_shift_red;
  logic [7:0]  ofs_shift_green, ofs_shift_blue;
  logic        pd_red, pd_green, pd_blue, pd_pll, clamp_connect;
  logic [10:0] clamp_ohms;
  logic [5:0]  sample_phase;
  logic [11:0] pixels_per_line;
  logic [9:0]  offset_dac_red, offset_dac_green, offset_dac_blue;
  int          errors = 0, num_checks = 0, cyc = 0;
  int unsigned ohm [8] = '{0, 1600, 800, 533, 400, 320, 267, 228};

  afepc_ctrl afepc_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .adc_red(adc), .adc_green(adc), .adc_blue(adc),
    .black_sample_valid(valid), .line_end, .pd_red, .pd_green, .pd_blue, .pd_pll,
    .clamp_connect, .clamp_ohms, .video_tuning_code(tune), .crystal_comp_value(xtal),
    .sample_phase, .pixels_per_line, .gain_red, .gain_green, .gain_blue,
    .ofs_shift_red, .ofs_shift_green, .ofs_shift_blue, .offset_dac_red,
    .offset_dac_green, .offset_dac_blue);

  always #5 pclk = ~pclk;

  // Hang guard, well above the longest servo sweep
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      give_verdict();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Two edges so outputs with one cycle of lag have landed
    repeat (2) @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic run_lines(input int n, input int k, input logic [7:0] v);
    repeat (n) begin
      repeat (k) begin
        @(posedge pclk);
        valid <= 1'b1;
        adc <= v;
      end
      @(posedge pclk);
      valid <= 1'b0;
      line_end <= 1'b1;
      @(posedge pclk);
      line_end <= 1'b0;
    end
    repeat (2) @(posedge pclk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rdchk("power", IDX_PWR, 32'h00);
    rdchk("tuning", IDX_TUNE, 32'h47);
    rdchk("clamp", IDX_CLAMP, 32'h08);
    rdchk("crystal", IDX_XTAL, 32'h14);
    chk("clamp_ohms", 32'h0, clamp_ohms);
    chk("gain_green", 32'h55, gain_green);
    chk("gain_blue", 32'h55, gain_blue);
    chk("ofs_green_rst", 32'h80, ofs_shift_green);
    chk("ofs_blue_rst", 32'h80, ofs_shift_blue);
  endtask

  task automatic t_power();
    for (int i = 0; i < 4; i++) begin
      wr(IDX_PWR, 32'h1 << i);
      chk("pd_bits", 32'h1 << i, {pd_pll, pd_blue, pd_green, pd_red});
    end
    wr(IDX_PWR, 32'hFF);
    rdchk("power_hi", IDX_PWR, 32'h0F);
    wr(IDX_PWR, 32'h00);
  endtask

  task automatic t_regs();
    wr(IDX_TUNE, 32'h49);
    chk("tuning_code", 32'h49, tune);
    for (int c = 0; c < 8; c++) begin
      wr(IDX_CLAMP, (c << 4) | 8);
      rdchk("clamp_rb", IDX_CLAMP, (c << 4) | 8);
      chk("clamp_on", c != 0, clamp_connect);
      chk("clamp_ohms", ohm[c], clamp_ohms);
    end
    wr(IDX_XTAL, 32'h5A);
    chk("crystal", 32'h5A, xtal);
    wr(IDX_PHASE, 32'hFF);
    chk("phase", 32'h3F, sample_phase);
    wr(IDX_PIXCNT, 32'h6A4);
    chk("pixcnt", 32'h6A4, pixels_per_line);
    apb(1'b0, 8'h00, 32'h0);
    chk("unmapped_err", 32'h1, err);
    chk("unmapped_data", 32'h0, rd);
  endtask

  task automatic t_lock();
    wr(IDX_BLC, 32'h01);
    wr(IDX_PWR, 32'h01);
    run_lines(32, 16, 8'h05);
    chk("dac_red_frozen", 32'h200, offset_dac_red);
    chk("dac_green", 32'h1FF, offset_dac_green);
    chk("dac_blue", 32'h1FF, offset_dac_blue);
    wr(IDX_DAC_R, 32'h100);
    chk("dac_wr_ignored", 32'h200, offset_dac_red);
    wr(IDX_GAIN_R, 32'hAA);
    wr(IDX_PWR, 32'h00);
    run_lines(32, 16, 8'h00);
    chk("gain_red", 32'hAA, gain_red);
    chk("dac_red_lock", 32'h200, offset_dac_red);
    chk("dac_green_lock", 32'h1FF, offset_dac_green);
    rdchk("status", IDX_STATUS, 32'h0F);
  endtask

  task automatic servo_case(input int w, input int t);
    wr(IDX_BLC, 32'h00);
    wr(IDX_DAC_R, 32'h200);
    wr(IDX_BLC, (t << 4) | (w << 2) | 1);
    run_lines(32 << t, (16 << w) - 1, 8'h05);
    chk("dac_short", 32'h200, offset_dac_red);
    run_lines((32 << t) - 1, 16 << w, 8'h05);
    chk("dac_early", 32'h200, offset_dac_red);
    run_lines(1, 16 << w, 8'h05);
    chk("dac_step", 32'h1FF, offset_dac_red);
  endtask

  task automatic t_manual();
    wr(IDX_BLC, 32'h00);
    wr(IDX_DAC_R, 32'h123);
    rdchk("dac_rb", IDX_DAC_R, 32'h123);
    chk("dac_red_fw", 32'h123, offset_dac_red);
    wr(IDX_OFS_R, 32'hFF);
    rdchk("ofs_raw", IDX_OFS_R, 32'hFF);
    chk("ofs_hi", 32'hC0, ofs_shift_red);
    wr(IDX_OFS_R, 32'h00);
    chk("ofs_lo", 32'h40, ofs_shift_red);
    wr(IDX_OFS_R, 32'h90);
    chk("ofs_mid", 32'h90, ofs_shift_red);
    wr(IDX_OFS_R + 8'h01, 32'hFF);
    chk("ofs_hi_green", 32'hC0, ofs_shift_green);
    wr(IDX_OFS_R + 8'h02, 32'h00);
    chk("ofs_lo_blue", 32'h40, ofs_shift_blue);
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_power();
    t_regs();
    t_lock();
    for (int i = 0; i < 4; i++) servo_case(i, 0);
    for (int i = 1; i < 4; i++) servo_case(0, i);
    t_manual();
    give_verdict();
  end
endmodule

bind afepc_ctrl afepc_ctrl_monitor afepc_ctrl_monitor_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .line_end, .pd_red, .pd_green, .pd_blue, .pd_pll,
  .clamp_connect, .clamp_ohms, .ofs_shift_red, .offset_dac_red);
